/* bench/kwb_keypad_wake_block_props.sv */
`default_nettype none
module kwb_keypad_wake_block_props
  import kwb_pkg::*;
(
  input wire logic CLK_SYS,
  input wire logic NRST,
  input wire logic STOP_MODE,
  input wire logic KEY_IRQ,
  input wire logic STOP_WAKE,
  input wire logic S_AXI_AWVALID,
  input wire logic S_AXI_AWREADY,
  input wire logic S_AXI_WVALID,
  input wire logic S_AXI_WREADY,
  input wire logic [1:0] S_AXI_BRESP,
  input wire logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [KWB_ADDR_W-1:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  input wire logic S_AXI_ARREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic [1:0] S_AXI_RRESP,
  input wire logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!NRST);
  sequence s_rd_taken;
    S_AXI_ARVALID && S_AXI_ARREADY;
  endsequence
  sequence s_wr_taken;
    S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
  endsequence
  a_b_answers: assert property (s_wr_taken |=> S_AXI_BVALID) else $error("write left unanswered");
  a_b_holds: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
    else $error("write response dropped early");
  a_b_blocks_aw: assert property (S_AXI_BVALID |-> !S_AXI_AWREADY) else $error("address taken during response");
  a_r_answers: assert property (s_rd_taken |=> S_AXI_RVALID) else $error("read left unanswered");
  a_r_holds: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
    else $error("read data dropped early");
  a_ack_reads_zero: assert property (s_rd_taken ##0 (S_AXI_ARADDR == KWB_ADDR_STATUS_CONTROL) |=>
    S_AXI_RDATA[KWB_ACK_BIT] == 1'b0) else $error("acknowledge bit read as one");
  a_unmapped_err: assert property (s_rd_taken ##0 (S_AXI_ARADDR != KWB_ADDR_STATUS_CONTROL &&
    S_AXI_ARADDR != KWB_ADDR_PIN_ENABLE) |=> S_AXI_RRESP == KWB_RESP_SLVERR) else $error("unmapped read not refused");
  a_irq_drop_cause: assert property ($fell(KEY_IRQ) |-> $past(S_AXI_BVALID) || $past(S_AXI_BVALID, 2))
    else $error("request dropped without a write");
  a_wake_off_run: assert property (!STOP_MODE [*2] |-> !STOP_WAKE)
    else $error("wake raised outside stop");
endmodule : kwb_keypad_wake_block_props
`default_nettype wire

/* bench/kwb_keypad_wake_block_tb_top.sv */
`default_nettype none
module kwb_keypad_wake_block_tb_top
  import kwb_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 0, nrst = 0, stop = 0, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0;
  logic awr, wr_rdy, bv, arr, rv, irq, wake;
  logic [3:0] awa = 4'h0, ara = 4'h0, strb = 4'h0;
  logic [31:0] wd = 32'h0, rdat;
  logic [1:0] br, rr;
  logic [7:0] want = 8'hFF, pins, rv8;
  int bad_count = 0, compares = 0, cyc = 0;
  logic [33:0] exp_r[$];
  logic [1:0] exp_b[$];
  localparam logic [3:0] SC = KWB_ADDR_STATUS_CONTROL;
  localparam logic [3:0] PE = KWB_ADDR_PIN_ENABLE;
  localparam logic [1:0] OK = KWB_RESP_OKAY;

  always #2.5 clk = ~clk;

  kwb_keys u_kwb_keys (.want(want), .pins(pins));
  kwb_keypad_wake_block u_kwb_keypad_wake_block (.CLK_SYS(clk), .NRST(nrst), .KEY_PINS(pins), .STOP_MODE(stop),
    .KEY_IRQ(irq), .STOP_WAKE(wake), .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr),
    .S_AXI_WDATA(wd), .S_AXI_WSTRB(strb), .S_AXI_WVALID(wv), .S_AXI_WREADY(wr_rdy), .S_AXI_BRESP(br),
    .S_AXI_BVALID(bv), .S_AXI_BREADY(bry), .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr),
    .S_AXI_RDATA(rdat), .S_AXI_RRESP(rr), .S_AXI_RVALID(rv), .S_AXI_RREADY(rry));

  task automatic cmp(input string n, input logic [33:0] e, input logic [33:0] s);
    compares++;
    if (s !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask : cmp

  task automatic summarize;
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : summarize

  // ---------------------------------------------------------------------------
  // Response watcher
  // ---------------------------------------------------------------------------
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (bv && bry) cmp("bresp", {32'h0, exp_b.pop_front()}, {32'h0, br});
    if (rv && rry) cmp("rdata", exp_r.pop_front(), {rr, rdat});
    if (cyc == 6000) begin
      bad_count++;
      summarize();
    end
  end

  task automatic wr(input logic [3:0] a, input logic [7:0] d, input logic [1:0] e);
    logic ad, dd;
    ad = 0;
    dd = 0;
    exp_b.push_back(e);
    awa <= a;
    wd <= {24'h0, d};
    strb <= 4'hF;
    awv <= 1;
    wv <= 1;
    bry <= 1;
    while (!(ad && dd)) begin
      @(posedge clk);
      if (awv && awr) begin
        ad = 1;
        awv <= 0;
      end
      if (wv && wr_rdy) begin
        dd = 1;
        wv <= 0;
      end
    end
    do @(posedge clk); while (!bv);
    bry <= 0;
    @(posedge clk);
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [7:0] d, input logic [1:0] e);
    exp_r.push_back({e, 24'h0, d});
    ara <= a;
    arv <= 1;
    rry <= 1;
    do @(posedge clk); while (!arr);
    arv <= 0;
    do @(posedge clk); while (!rv);
    rry <= 0;
    @(posedge clk);
  endtask : rd

  // Pins pass two sync stages, flag and request flops; eight cycles cover it.
  task automatic keys(input logic [7:0] v);
    want <= v;
    repeat (8) @(posedge clk);
  endtask : keys

  // ---------------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------------
  initial begin
    void'($urandom(32'h8f1e));
    repeat (12) @(posedge clk);
    nrst <= 1;
    @(posedge clk);
    rd(SC, 8'h00, OK);
    rd(PE, 8'h00, OK);
    rd(4'h8, 8'h00, KWB_RESP_SLVERR);
    wr(4'hC, 8'hFF, KWB_RESP_SLVERR);
    rv8 = 8'($urandom);
    wr(PE, rv8, OK);
    rd(PE, rv8, OK);
    wr(PE, 8'h01, OK);
    wr(SC, 8'hF2, OK);
    keys(8'hFE);
    cmp("irq", 34'h1, {33'h0, irq});
    rd(SC, 8'hFA, OK);
    wr(SC, 8'hF6, OK);
    rd(SC, 8'hF2, OK);
    cmp("irq", 34'h0, {33'h0, irq});
    wr(SC, 8'hF7, OK);
    rd(SC, 8'hFB, OK);
    keys(8'hFF);
    wr(SC, 8'hF7, OK);
    rd(SC, 8'hF3, OK);
    wr(SC, 8'h80, OK);
    wr(PE, 8'h80, OK);
    keys(8'h7F);
    wr(SC, 8'h84, OK);
    keys(8'h77);
    rd(SC, 8'h80, OK);
    keys(8'hF7);
    rd(SC, 8'h88, OK);
    cmp("irq", 34'h0, {33'h0, irq});
    wr(SC, 8'h84, OK);
    keys(8'h7F);
    stop <= 1;
    repeat (4) @(posedge clk);
    cmp("wake", 34'h0, {33'h0, wake});
    keys(8'hFF);
    cmp("wake", 34'h1, {33'h0, wake});
    stop <= 0;
    repeat (3) @(posedge clk);
    cmp("wake", 34'h0, {33'h0, wake});
    summarize();
  end
endmodule : kwb_keypad_wake_block_tb_top

bind kwb_keypad_wake_block kwb_keypad_wake_block_props u_props (.CLK_SYS(CLK_SYS), .NRST(NRST),
  .STOP_MODE(STOP_MODE), .KEY_IRQ(KEY_IRQ), .STOP_WAKE(STOP_WAKE), .S_AXI_AWVALID(S_AXI_AWVALID),
  .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY),
  .S_AXI_BRESP(S_AXI_BRESP), .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY),
  .S_AXI_ARADDR(S_AXI_ARADDR), .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY),
  .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RRESP(S_AXI_RRESP), .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY));
`default_nettype wire

/* bench/kwb_keys.sv */
`default_nettype none
module kwb_keys (
  input wire logic [7:0] want,
  output logic [7:0] pins
);
  timeunit 1ns;
  timeprecision 100ps;
  // Contacts settle off the clock grid, so the pins look asynchronous.
  initial pins = 8'hFF;
  always @(want) pins <= #1.3 want;
endmodule : kwb_keys
`default_nettype wire

/* rtl/kwb_keypad_wake_block.sv */
// What this block does
// - Polarity bit picks falling/low or rising/high.
// - Pins 3..0 fixed falling/low; 7..4 programmable.
// - Flag bit 3 sets on any enabled trigger.
// - Acknowledge bit 2 write-only, reads zero.
// - Edge mode: acknowledge clears flag unless a trigger is detected in the same cycle.
// - Level mode: flag re-sets while any asserted.
// - Interrupt enable gates flag onto request.
// - Mode bit: 0 edge only, 1 edge-and-level.
// - Pin enable bit connects pin to detector.
// - Falling edge: high one cycle, low next.
// - Rising edge: low one cycle, high next.
// - Edge needs prior deasserted level, clocked detection.
// - Edge-and-level mode: edge counts when other enabled pins deasserted; edge mode takes any edge.
// - Stop mode: enabled asserted inputs wake asynchronously.
`default_nettype none
module kwb_keypad_wake_block
  import kwb_pkg::*;
#(
  parameter int NUM_PINS = KWB_NUM_PINS
) (
  input wire logic CLK_SYS,
  input wire logic NRST,
  input wire logic [NUM_PINS-1:0] KEY_PINS,
  input wire logic STOP_MODE,
  output logic KEY_IRQ,
  output logic STOP_WAKE,
  input wire logic [KWB_ADDR_W-1:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [KWB_ADDR_W-1:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY
);
  // ---------------------------------------------------------------------------
  // Configuration and status state
  // ---------------------------------------------------------------------------
  logic [3:0] pin_polarity_select_r, pin_polarity_select_nxt;
  logic key_irq_enable_r, key_irq_enable_nxt;
  kwb_mode_t detect_mode_select_r, detect_mode_select_nxt;
  logic [NUM_PINS-1:0] pin_enable_mask_r, pin_enable_mask_nxt;
  logic key_event_flag_r, key_event_flag_nxt;
  logic [NUM_PINS-1:0] prev_asserted_r, prev_asserted_nxt;
  logic key_irq_r, key_irq_nxt;
  logic stop_wake_r, stop_wake_nxt;

  // ---------------------------------------------------------------------------
  // AXI4-Lite state
  // ---------------------------------------------------------------------------
  logic aw_held_r, aw_held_nxt;
  logic [KWB_ADDR_W-1:0] aw_addr_r, aw_addr_nxt;
  logic w_held_r, w_held_nxt;
  logic [31:0] w_data_r, w_data_nxt;
  logic w_strb0_r, w_strb0_nxt;
  logic bvalid_r, bvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt;
  logic rvalid_r, rvalid_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [1:0] rresp_r, rresp_nxt;

  logic [NUM_PINS-1:0] pins_sync;
  logic [NUM_PINS-1:0] polarity;
  logic [NUM_PINS-1:0] level_match;
  logic [NUM_PINS-1:0] asserted;
  logic [NUM_PINS-1:0] edge_hit;
  logic edge_event;
  logic level_event;
  logic wr_fire;
  logic wr_ack;
  logic [7:0] sc_read;

  // ---------------------------------------------------------------------------
  // Pin synchroniser
  // ---------------------------------------------------------------------------
  kwb_sync #(
    .WIDTH(NUM_PINS)
  ) u_sync (
    .clk(CLK_SYS),
    .rst_n(NRST),
    .d(KEY_PINS),
    .q(pins_sync)
  );

  function automatic logic addr_known(input logic [KWB_ADDR_W-1:0] a);
    return (a == KWB_ADDR_STATUS_CONTROL) || (a == KWB_ADDR_PIN_ENABLE);
  endfunction : addr_known

  // ---------------------------------------------------------------------------
  // Trigger detection
  // ---------------------------------------------------------------------------
  // A pin is "asserted" when its synchronised level matches its selected
  // polarity; pins 3..0 always look for low, pins 7..4 follow their select bit.
  always_comb begin
    polarity = '0;
    polarity[KWB_POL_MSB:KWB_POL_LSB] = pin_polarity_select_r;
    level_match = pins_sync ~^ polarity;
    asserted = level_match & pin_enable_mask_r;
    // History is kept for disabled pins too, so enabling a pin that already
    // sits at its asserted level is not taken as an edge.
    edge_hit = asserted & ~prev_asserted_r;
    if (detect_mode_select_r == KWB_MODE_EDGE_LEVEL) begin
      // Other enabled pins must have been deasserted as well.
      edge_event = (|edge_hit) && ((prev_asserted_r & pin_enable_mask_r & ~edge_hit) == '0);
    end else begin
      edge_event = |edge_hit;
    end
    level_event = (detect_mode_select_r == KWB_MODE_EDGE_LEVEL) && (|asserted);
  end

  // ---------------------------------------------------------------------------
  // Register writes and flag
  // ---------------------------------------------------------------------------
  assign wr_fire = (aw_held_r || S_AXI_AWVALID) && (w_held_r || S_AXI_WVALID) && !bvalid_r;

  always_comb begin
    logic [KWB_ADDR_W-1:0] waddr;
    logic [31:0] wdata;
    logic wstrb0;
    waddr = aw_held_r ? aw_addr_r : S_AXI_AWADDR;
    wdata = w_held_r ? w_data_r : S_AXI_WDATA;
    wstrb0 = w_held_r ? w_strb0_r : S_AXI_WSTRB[0];
    pin_polarity_select_nxt = pin_polarity_select_r;
    key_irq_enable_nxt = key_irq_enable_r;
    detect_mode_select_nxt = detect_mode_select_r;
    pin_enable_mask_nxt = pin_enable_mask_r;
    wr_ack = 1'b0;
    if (wr_fire && wstrb0) begin
      if (waddr == KWB_ADDR_STATUS_CONTROL) begin
        pin_polarity_select_nxt = wdata[KWB_POL_MSB:KWB_POL_LSB];
        key_irq_enable_nxt = wdata[KWB_IRQEN_BIT];
        detect_mode_select_nxt = kwb_mode_t'(wdata[KWB_MODE_BIT]);
        wr_ack = wdata[KWB_ACK_BIT];
      end else if (waddr == KWB_ADDR_PIN_ENABLE) begin
        pin_enable_mask_nxt = wdata[NUM_PINS-1:0];
      end
    end
    // Detection wins over acknowledge in the same cycle.
    if (edge_event || level_event) begin
      key_event_flag_nxt = 1'b1;
    end else if (wr_ack) begin
      key_event_flag_nxt = 1'b0;
    end else begin
      key_event_flag_nxt = key_event_flag_r;
    end
    prev_asserted_nxt = level_match;
    key_irq_nxt = key_irq_enable_r && key_event_flag_r;
    // Raw pins, no clocked history: wake works even with clocks stopped.
    stop_wake_nxt = 1'b0;
  end

  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      pin_polarity_select_r <= KWB_POL_RST;
      key_irq_enable_r <= KWB_IRQEN_RST;
      detect_mode_select_r <= kwb_mode_t'(KWB_MODE_RST);
      pin_enable_mask_r <= KWB_PIN_ENABLE_RST;
      key_event_flag_r <= 1'b0;
      prev_asserted_r <= '0;
      key_irq_r <= 1'b0;
    end else begin
      pin_polarity_select_r <= pin_polarity_select_nxt;
      key_irq_enable_r <= key_irq_enable_nxt;
      detect_mode_select_r <= detect_mode_select_nxt;
      pin_enable_mask_r <= pin_enable_mask_nxt;
      key_event_flag_r <= key_event_flag_nxt;
      prev_asserted_r <= prev_asserted_nxt;
      key_irq_r <= key_irq_nxt;
    end
  end

  // ---------------------------------------------------------------------------
  // Stop-mode wake
  // ---------------------------------------------------------------------------
  // This flop is set asynchronously by any enabled pin at its asserted level
  // while stop mode holds, bypassing the edge detector; it clears on the first
  // bus clock after the pins release or stop mode ends.
  logic stop_raw;
  assign stop_raw = STOP_MODE && (|((KEY_PINS ~^ polarity) & pin_enable_mask_r));

  always_ff @(posedge CLK_SYS or negedge NRST or posedge stop_raw) begin
    if (!NRST) begin
      stop_wake_r <= 1'b0;
    end else if (stop_raw) begin
      stop_wake_r <= 1'b1;
    end else begin
      stop_wake_r <= stop_wake_nxt;
    end
  end

  // ---------------------------------------------------------------------------
  // AXI4-Lite slave
  // ---------------------------------------------------------------------------
  always_comb begin
    logic [KWB_ADDR_W-1:0] waddr;
    waddr = aw_held_r ? aw_addr_r : S_AXI_AWADDR;
    aw_held_nxt = aw_held_r;
    aw_addr_nxt = aw_addr_r;
    w_held_nxt = w_held_r;
    w_data_nxt = w_data_r;
    w_strb0_nxt = w_strb0_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    if (S_AXI_AWVALID && !aw_held_r && !bvalid_r && !wr_fire) begin
      aw_held_nxt = 1'b1;
      aw_addr_nxt = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && !w_held_r && !bvalid_r && !wr_fire) begin
      w_held_nxt = 1'b1;
      w_data_nxt = S_AXI_WDATA;
      w_strb0_nxt = S_AXI_WSTRB[0];
    end
    if (wr_fire) begin
      aw_held_nxt = 1'b0;
      w_held_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = addr_known(waddr) ? KWB_RESP_OKAY : KWB_RESP_SLVERR;
    end
    if (bvalid_r && S_AXI_BREADY) begin
      bvalid_nxt = 1'b0;
    end
  end

  always_comb begin
    sc_read = '0;
    sc_read[KWB_POL_MSB:KWB_POL_LSB] = pin_polarity_select_r;
    sc_read[KWB_FLAG_BIT] = key_event_flag_r;
    sc_read[KWB_ACK_BIT] = 1'b0;
    sc_read[KWB_IRQEN_BIT] = key_irq_enable_r;
    sc_read[KWB_MODE_BIT] = detect_mode_select_r;
    rvalid_nxt = rvalid_r;
    rdata_nxt = rdata_r;
    rresp_nxt = rresp_r;
    if (rvalid_r && S_AXI_RREADY) begin
      rvalid_nxt = 1'b0;
    end
    if (S_AXI_ARVALID && !rvalid_r) begin
      rvalid_nxt = 1'b1;
      rresp_nxt = addr_known(S_AXI_ARADDR) ? KWB_RESP_OKAY : KWB_RESP_SLVERR;
      if (S_AXI_ARADDR == KWB_ADDR_STATUS_CONTROL) begin
        rdata_nxt = {24'h000000, sc_read};
      end else if (S_AXI_ARADDR == KWB_ADDR_PIN_ENABLE) begin
        rdata_nxt = {{(32 - NUM_PINS){1'b0}}, pin_enable_mask_r};
      end else begin
        rdata_nxt = 32'h00000000;
      end
    end
  end

  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      aw_held_r <= 1'b0;
      aw_addr_r <= '0;
      w_held_r <= 1'b0;
      w_data_r <= 32'h00000000;
      w_strb0_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= KWB_RESP_OKAY;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h00000000;
      rresp_r <= KWB_RESP_OKAY;
    end else begin
      aw_held_r <= aw_held_nxt;
      aw_addr_r <= aw_addr_nxt;
      w_held_r <= w_held_nxt;
      w_data_r <= w_data_nxt;
      w_strb0_r <= w_strb0_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      rvalid_r <= rvalid_nxt;
      rdata_r <= rdata_nxt;
      rresp_r <= rresp_nxt;
    end
  end

  // ---------------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------------
  // Ready flags are combinational: a channel is taken in the cycle it is seen.
  assign S_AXI_AWREADY = !aw_held_r && !bvalid_r;
  assign S_AXI_WREADY = !w_held_r && !bvalid_r;
  assign S_AXI_BVALID = bvalid_r;
  assign S_AXI_BRESP = bresp_r;
  assign S_AXI_ARREADY = !rvalid_r;
  assign S_AXI_RVALID = rvalid_r;
  assign S_AXI_RDATA = rdata_r;
  assign S_AXI_RRESP = rresp_r;
  assign KEY_IRQ = key_irq_r;
  assign STOP_WAKE = stop_wake_r;
endmodule : kwb_keypad_wake_block
`default_nettype wire

/* rtl/kwb_pkg.sv */
`default_nettype none
package kwb_pkg;
  // ---------------------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------------------
  localparam logic [3:0] KWB_ADDR_STATUS_CONTROL = 4'h0;
  localparam logic [3:0] KWB_ADDR_PIN_ENABLE = 4'h4;
  localparam int KWB_ADDR_W = 4;
  localparam int KWB_NUM_PINS = 8;

  // ---------------------------------------------------------------------------
  // Status/control field positions
  // ---------------------------------------------------------------------------
  localparam int KWB_POL_LSB = 4;
  localparam int KWB_POL_MSB = 7;
  localparam int KWB_FLAG_BIT = 3;
  localparam int KWB_ACK_BIT = 2;
  localparam int KWB_IRQEN_BIT = 1;
  localparam int KWB_MODE_BIT = 0;

  // ---------------------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------------------
  localparam logic [3:0] KWB_POL_RST = 4'h0;
  localparam logic [7:0] KWB_PIN_ENABLE_RST = 8'h00;
  localparam logic KWB_IRQEN_RST = 1'b0;
  localparam logic KWB_MODE_RST = 1'b0;

  // ---------------------------------------------------------------------------
  // AXI responses
  // ---------------------------------------------------------------------------
  localparam logic [1:0] KWB_RESP_OKAY = 2'h0;
  localparam logic [1:0] KWB_RESP_SLVERR = 2'h2;

  typedef enum logic {
    KWB_MODE_EDGE = 1'b0,
    KWB_MODE_EDGE_LEVEL = 1'b1
  } kwb_mode_t;
endpackage : kwb_pkg
`default_nettype wire

/* rtl/kwb_sync.sv */
`default_nettype none
module kwb_sync
  import kwb_pkg::*;
#(
  parameter int WIDTH = KWB_NUM_PINS
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] meta_nxt;
  logic [WIDTH-1:0] q_r;
  logic [WIDTH-1:0] q_nxt;

  // The first stage feeds only the second stage.
  always_comb begin
    meta_nxt = d;
    q_nxt = meta_r;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      // Start at the idle-high level of the keys so no false edge follows reset.
      meta_r <= '1;
      q_r <= '1;
    end else begin
      meta_r <= meta_nxt;
      q_r <= q_nxt;
    end
  end

  assign q = q_r;
endmodule : kwb_sync
`default_nettype wire
